// ---- rtl/scwe_defines.vh ----
// constants of the sync channel word encoder: register map, reset values,
// sync type codes, classification selectors and word slot lengths.
// assumes inclusion by bare name from rtl/ files only.
`ifndef SCWE_DEFINES_VH
`define SCWE_DEFINES_VH

// register addresses
`define SCWE_ADDR_DATA_TRAIN 8'h82
`define SCWE_ADDR_SYNC_ID 8'h83
`define SCWE_ADDR_BLACK_CODE 8'h84
`define SCWE_ADDR_IMAGE_CODE 8'h85
`define SCWE_ADDR_CRC_CODE 8'h86
`define SCWE_ADDR_TRAIN_CODE 8'h87
`define SCWE_ADDR_FORMAT 8'h88

// register reset values
`define SCWE_RST_DATA_TRAIN 10'h3a6
`define SCWE_RST_SYNC_ID 10'h02a
`define SCWE_RST_BLACK_CODE 10'h015
`define SCWE_RST_IMAGE_CODE 10'h035
`define SCWE_RST_CRC_CODE 10'h059
`define SCWE_RST_TRAIN_CODE 10'h3a6
`define SCWE_RST_FORMAT 1'h0

// sync type field values
`define SCWE_TYPE_FRAME_BEGIN 3'h5
`define SCWE_TYPE_FRAME_FINISH 3'h6
`define SCWE_TYPE_ROW_BEGIN 3'h1
`define SCWE_TYPE_ROW_FINISH 3'h2

// sync request selector from the sequencer
`define SCWE_SYNC_NONE 3'h0
`define SCWE_SYNC_FRAME_BEGIN 3'h1
`define SCWE_SYNC_FRAME_FINISH 3'h2
`define SCWE_SYNC_ROW_BEGIN 3'h3
`define SCWE_SYNC_ROW_FINISH 3'h4

// data class selector from the sequencer
`define SCWE_CLASS_TRAINING 2'h0
`define SCWE_CLASS_BLACK 2'h1
`define SCWE_CLASS_IMAGE 2'h2
`define SCWE_CLASS_CRC 2'h3

// link clock edges (both edges count, ddr) per word slot
`define SCWE_SLOT_EDGES_10 4'ha
`define SCWE_SLOT_EDGES_8 4'h8

`endif

// ---- rtl/scwe_link_slot.v ----
// word slot timing: samples the link clock and emits one tick per word.
// assumes link_clk is asynchronous to clk and much slower (80 ns vs 8 ns).
`timescale 1ns/1ps
`include "scwe_defines.vh"

module scwe_link_slot (
  // clock and reset
  input wire clk,
  input wire rst,
  // link side
  input wire link_clk,
  input wire mode_8bit,
  // slot timing
  output reg slot_tick
);

reg link_meta;
reg link_sync;
reg link_prev;
reg [3:0] edge_cnt;
wire link_edge;
wire [3:0] edges_per_slot;

assign link_edge = link_sync ^ link_prev;
assign edges_per_slot = mode_8bit ? `SCWE_SLOT_EDGES_8 : `SCWE_SLOT_EDGES_10;

always @(posedge clk) begin
  if (rst) begin
    link_meta <= 1'b0;
    link_sync <= 1'b0;
    link_prev <= 1'b0;
  end else begin
    link_meta <= link_clk;
    link_sync <= link_meta;
    link_prev <= link_sync;
  end
end

// one slot per word length of ddr bits
always @(posedge clk) begin
  if (rst) begin
    edge_cnt <= 4'h0;
    slot_tick <= 1'b0;
  end else begin
    slot_tick <= 1'b0;
    if (link_edge) begin
      if (edge_cnt >= edges_per_slot - 4'h1) begin
        edge_cnt <= 4'h0;
        slot_tick <= 1'b1;
      end else begin
        edge_cnt <= edge_cnt + 4'h1;
      end
    end
  end
end

endmodule // scwe_link_slot

// ---- rtl/scwe_win_prio.v ----
// highest active window finder over 32 window flags.
// assumes flags come from logic on the same clock.
`timescale 1ns/1ps

module scwe_win_prio (
  // window flags
  input wire [31:0] win_active,
  // result
  output reg [4:0] win_id,
  output reg win_any
);

integer i;

// later (higher) index overrides lower ones
always @* begin
  win_id = 5'h00;
  win_any = 1'b0;
  for (i = 0; i < 32; i = i + 1) begin
    if (win_active[i]) begin
      win_id = i[4:0];
      win_any = 1'b1;
    end
  end
end

endmodule // scwe_win_prio

// ---- rtl/scwe_sync_encoder.v ----
// sync channel word encoder: builds sync, window number and class words
// and the 32 data channel words for each word slot of the link.
// assumes the sequencer on clk presents slot requests, held until slot_taken;
// link_clk and adc_mode come from outside the clock domain.
`timescale 1ns/1ps
`include "scwe_defines.vh"

module scwe_sync_encoder (
  // clock and reset
  input wire clk,
  input wire rst,
  // link clock and mode pin
  input wire link_clk,
  input wire adc_mode,
  // register port
  input wire [7:0] reg_addr,
  input wire [9:0] reg_wdata,
  input wire reg_wr,
  output reg [9:0] reg_rdata,
  // sequencer request for the next slot
  input wire [2:0] sync_req,
  input wire [1:0] class_req,
  input wire [31:0] win_active,
  input wire [319:0] pix_data,
  output reg slot_taken,
  // slot output to the serializers
  output reg [9:0] sync_word,
  output reg [319:0] chan_data,
  output reg word_valid,
  output reg window_word,
  // status
  output reg mode_conflict,
  output reg seq_error
);

////////////////////////////////////////////////////////////////////////////////
// functions

// sync type code for a request selector
function [2:0] type_code;
  input [2:0] req;
  begin
    case (req)
      `SCWE_SYNC_FRAME_BEGIN: type_code = `SCWE_TYPE_FRAME_BEGIN;
      `SCWE_SYNC_FRAME_FINISH: type_code = `SCWE_TYPE_FRAME_FINISH;
      `SCWE_SYNC_ROW_BEGIN: type_code = `SCWE_TYPE_ROW_BEGIN;
      `SCWE_SYNC_ROW_FINISH: type_code = `SCWE_TYPE_ROW_FINISH;
      default: type_code = 3'h0;
    endcase
  end
endfunction

// word narrowing: 8-bit mode keeps bits 9:2 in the low byte
function [9:0] fit_word;
  input [9:0] w;
  input m8;
  begin
    if (m8) begin
      fit_word = {2'h0, w[9:2]};
    end else begin
      fit_word = w;
    end
  end
endfunction

// register index for an address; shared by the write and read decoders
localparam SEL_DATA_TRAIN = 3'h0;
localparam SEL_SYNC_ID = 3'h1;
localparam SEL_BLACK_CODE = 3'h2;
localparam SEL_IMAGE_CODE = 3'h3;
localparam SEL_CRC_CODE = 3'h4;
localparam SEL_TRAIN_CODE = 3'h5;
localparam SEL_FORMAT = 3'h6;
localparam SEL_NONE = 3'h7;

function [2:0] reg_sel;
  input [7:0] addr;
  begin
    case (addr)
      `SCWE_ADDR_DATA_TRAIN: reg_sel = SEL_DATA_TRAIN;
      `SCWE_ADDR_SYNC_ID: reg_sel = SEL_SYNC_ID;
      `SCWE_ADDR_BLACK_CODE: reg_sel = SEL_BLACK_CODE;
      `SCWE_ADDR_IMAGE_CODE: reg_sel = SEL_IMAGE_CODE;
      `SCWE_ADDR_CRC_CODE: reg_sel = SEL_CRC_CODE;
      `SCWE_ADDR_TRAIN_CODE: reg_sel = SEL_TRAIN_CODE;
      `SCWE_ADDR_FORMAT: reg_sel = SEL_FORMAT;
      default: reg_sel = SEL_NONE;
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// mode pin synchroniser

reg adc_meta;
reg adc_sync;
reg format_8bit;
wire mode_8bit;

// limitation: moving the pin outside reset can cut one slot short
always @(posedge clk) begin
  if (rst) begin
    adc_meta <= 1'b0;
    adc_sync <= 1'b0;
  end else begin
    adc_meta <= adc_mode;
    adc_sync <= adc_meta;
  end
end

// the pin sets the word width; the format bit only has to agree
assign mode_8bit = adc_sync;

////////////////////////////////////////////////////////////////////////////////
// configuration registers

reg [9:0] data_training_pattern;
reg [9:0] sync_identifier;
reg [9:0] black_class_code;
reg [9:0] image_class_code;
reg [9:0] crc_class_code;
reg [9:0] training_class_code;
wire [2:0] addr_sel;

// one decode feeds both the write and the read path
assign addr_sel = reg_sel(reg_addr);

always @(posedge clk) begin
  if (rst) begin
    data_training_pattern <= `SCWE_RST_DATA_TRAIN;
    sync_identifier <= `SCWE_RST_SYNC_ID;
    black_class_code <= `SCWE_RST_BLACK_CODE;
    image_class_code <= `SCWE_RST_IMAGE_CODE;
    crc_class_code <= `SCWE_RST_CRC_CODE;
    training_class_code <= `SCWE_RST_TRAIN_CODE;
    format_8bit <= `SCWE_RST_FORMAT;
  end else if (reg_wr) begin
    case (addr_sel)
      SEL_DATA_TRAIN: data_training_pattern <= reg_wdata;
      SEL_SYNC_ID: sync_identifier <= reg_wdata;
      SEL_BLACK_CODE: black_class_code <= reg_wdata;
      SEL_IMAGE_CODE: image_class_code <= reg_wdata;
      SEL_CRC_CODE: crc_class_code <= reg_wdata;
      SEL_TRAIN_CODE: training_class_code <= reg_wdata;
      SEL_FORMAT: format_8bit <= reg_wdata[0];
      default: format_8bit <= format_8bit;
    endcase
  end
end

// read data one cycle after the address; unmapped reads as zero
always @(posedge clk) begin
  if (rst) begin
    reg_rdata <= 10'h000;
  end else begin
    case (addr_sel)
      SEL_DATA_TRAIN: reg_rdata <= data_training_pattern;
      SEL_SYNC_ID: reg_rdata <= sync_identifier;
      SEL_BLACK_CODE: reg_rdata <= black_class_code;
      SEL_IMAGE_CODE: reg_rdata <= image_class_code;
      SEL_CRC_CODE: reg_rdata <= crc_class_code;
      SEL_TRAIN_CODE: reg_rdata <= training_class_code;
      SEL_FORMAT: reg_rdata <= {8'h00, adc_sync, format_8bit};
      default: reg_rdata <= 10'h000;
    endcase
  end
end

// flags a format bit that disagrees with the pin; the pin still wins
always @(posedge clk) begin
  if (rst) begin
    mode_conflict <= 1'b0;
  end else begin
    mode_conflict <= format_8bit ^ adc_sync;
  end
end

////////////////////////////////////////////////////////////////////////////////
// slot timing and window priority

wire slot_tick;
wire [4:0] top_win;
wire any_win;

// both link edges count: five link periods per 10-bit slot
scwe_link_slot u_slot (
  .clk(clk),
  .rst(rst),
  .link_clk(link_clk),
  .mode_8bit(mode_8bit),
  .slot_tick(slot_tick)
);

// purely combinational; the result is only sampled on a slot tick
scwe_win_prio u_prio (
  .win_active(win_active),
  .win_id(top_win),
  .win_any(any_win)
);

////////////////////////////////////////////////////////////////////////////////
// sync channel word selection

// a window number is owed after every sync word, frame or row
reg id_pending;
reg [4:0] id_hold;
reg [9:0] next_sync_word;
reg next_is_id;
reg [9:0] class_word;
wire [9:0] sync_code_10;
wire [9:0] sync_code_8;
wire sync_now;

assign sync_now = (sync_req != `SCWE_SYNC_NONE) && !id_pending;
assign sync_code_10 = {type_code(sync_req), sync_identifier[6:0]};
assign sync_code_8 = {2'h0, type_code(sync_req), sync_identifier[6:2]};

always @* begin
  case (class_req)
    `SCWE_CLASS_BLACK: class_word = black_class_code;
    `SCWE_CLASS_IMAGE: class_word = image_class_code;
    `SCWE_CLASS_CRC: class_word = crc_class_code;
    default: class_word = training_class_code;
  endcase
end

// priority: owed window number, then sync code, then class code
always @* begin
  next_is_id = 1'b0;
  if (id_pending) begin
    next_is_id = 1'b1;
    if (mode_8bit) begin
      next_sync_word = {3'h0, id_hold, 2'h0};
    end else begin
      next_sync_word = {5'h00, id_hold};
    end
  end else if (sync_now) begin
    if (mode_8bit) begin
      next_sync_word = sync_code_8;
    end else begin
      next_sync_word = sync_code_10;
    end
  end else begin
    next_sync_word = fit_word(class_word, mode_8bit);
  end
end

always @(posedge clk) begin
  if (rst) begin
    id_pending <= 1'b0;
    id_hold <= 5'h00;
  end else if (slot_tick) begin
    if (id_pending) begin
      id_pending <= 1'b0;
    end else if (sync_now) begin
      // black lines also carry the number; the receiver drops it
      id_pending <= 1'b1;
      id_hold <= top_win;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// data channel words

wire training_slot;
wire [9:0] train_word;

// sync and window number slots always carry pixels, never training
assign training_slot = !id_pending && !sync_now && (class_req == `SCWE_CLASS_TRAINING);
assign train_word = fit_word(data_training_pattern, mode_8bit);

// one flop group per channel; training and pixels share the slot tick
genvar ch;
generate
  for (ch = 0; ch < 32; ch = ch + 1) begin : g_chan
    always @(posedge clk) begin
      if (rst) begin
        chan_data[ch*10 +: 10] <= 10'h000;
      end else if (slot_tick) begin
        if (training_slot) begin
          chan_data[ch*10 +: 10] <= train_word;
        end else begin
          chan_data[ch*10 +: 10] <= fit_word(pix_data[ch*10 +: 10], mode_8bit);
        end
      end
    end
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// slot outputs

// sync word and data words update on the same tick
always @(posedge clk) begin
  if (rst) begin
    sync_word <= 10'h000;
    word_valid <= 1'b0;
    window_word <= 1'b0;
    slot_taken <= 1'b0;
  end else begin
    word_valid <= slot_tick;
    // a window slot leaves the request standing for the next slot
    slot_taken <= slot_tick && !id_pending;
    if (slot_tick) begin
      sync_word <= next_sync_word;
      window_word <= next_is_id;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// bracket tracking

// row codes must alternate; a frame begin opens a row too
reg row_open;

always @(posedge clk) begin
  if (rst) begin
    row_open <= 1'b0;
    seq_error <= 1'b0;
  end else if (slot_tick && sync_now) begin
    case (sync_req)
      `SCWE_SYNC_FRAME_BEGIN, `SCWE_SYNC_ROW_BEGIN: begin
        if (row_open) begin
          seq_error <= 1'b1;
        end
        row_open <= 1'b1;
      end
      `SCWE_SYNC_FRAME_FINISH, `SCWE_SYNC_ROW_FINISH: begin
        if (!row_open) begin
          seq_error <= 1'b1;
        end
        row_open <= 1'b0;
      end
      default: row_open <= row_open;
    endcase
  end
end

endmodule // scwe_sync_encoder

// ---- verif/scwe_rx_model.v.sv ----
// far side model: host link clock source, mode pin
// assumes the bench changes eight_bit only just before it holds the encoder in reset
`timescale 1ns/1ps
module scwe_rx_model (
  // control from bench
  input wire eight_bit,
  // link side
  output reg link_clk,
  output wire adc_mode
);
  // host clock runs free, phase unrelated to clk
  initial begin
    link_clk = 1'b0;
    #3;
    forever #40 link_clk = ~link_clk;
  end
  // continuous, so the pin has a level from time zero
  assign adc_mode = eight_bit;
endmodule // scwe_rx_model

// ---- verif/scwe_checker.sv ----
// assertions on the encoder top ports
// assumes adc_mode only changes while rst is high
`timescale 1ns/1ps
module scwe_checker (
  // clock and reset
  input wire clk,
  input wire rst,
  // watched ports
  input wire adc_mode,
  input wire [2:0] sync_req,
  input wire slot_taken,
  input wire [9:0] sync_word,
  input wire [319:0] chan_data,
  input wire word_valid,
  input wire window_word
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  chk_window_follows: assert property (
    slot_taken && $past(sync_req) != 3'h0 |=> first_match(##[0:79] word_valid) ##0 window_word)
    else $error("no window word after sync word");
  chk_window_untaken: assert property (
    word_valid && window_word |-> !slot_taken) else $error("window slot took request");
  chk_window_wide: assert property (
    word_valid && window_word && !adc_mode |-> sync_word[9:5] == 5'h00) else $error("bad wide window word");
  chk_window_narrow: assert property (
    word_valid && window_word && adc_mode |-> sync_word[9:7] == 3'h0 && sync_word[1:0] == 2'h0)
    else $error("bad narrow window word");
  chk_narrow_words: assert property (
    word_valid && adc_mode |-> sync_word[9:8] == 2'h0 && chan_data[9:8] == 2'h0) else $error("wide bits set");
  chk_single_pulse: assert property (
    word_valid |=> !word_valid [*8]) else $error("word slots too close");
  chk_taken_slot: assert property (
    slot_taken |-> word_valid) else $error("take without word");
  chk_words_stand: assert property (
    !word_valid |-> $stable(sync_word) && $stable(chan_data)) else $error("word changed mid slot");
endmodule // scwe_checker

bind scwe_sync_encoder scwe_checker u_chk (.clk(clk), .rst(rst), .adc_mode(adc_mode), .sync_req(sync_req),
  .slot_taken(slot_taken), .sync_word(sync_word), .chan_data(chan_data), .word_valid(word_valid),
  .window_word(window_word));

// ---- verif/scwe_sync_encoder_test.sv ----
// bench for the sync channel word encoder: registers, frame codes, classes, both widths
// assumes the receiver model supplies the link clock and the mode pin
`timescale 1ns/1ps
module scwe_sync_encoder_test;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg eight_bit = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [9:0] reg_wdata = 10'h000;
  reg reg_wr = 1'b0;
  reg [2:0] sync_req = 3'h0;
  reg [1:0] class_req = 2'h0;
  reg [31:0] win_active = 32'h00000105;
  reg [319:0] pix_data = {32{10'h2c7}};
  reg [9:0] sid = 10'h02a;
  reg [9:0] dtrain = 10'h3a6;
  wire link_clk;
  wire adc_mode;
  wire [9:0] reg_rdata;
  wire slot_taken;
  wire [9:0] sync_word;
  wire [319:0] chan_data;
  wire word_valid;
  wire window_word;
  wire mode_conflict;
  wire seq_error;
  integer bad_count = 0;
  integer check_count = 0;
  integer i;
  always #4 clk = ~clk;
  scwe_rx_model u_rx (.eight_bit(eight_bit), .link_clk(link_clk), .adc_mode(adc_mode));
  scwe_sync_encoder u_dut (.clk(clk), .rst(rst), .link_clk(link_clk), .adc_mode(adc_mode), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .sync_req(sync_req), .class_req(class_req),
    .win_active(win_active), .pix_data(pix_data), .slot_taken(slot_taken), .sync_word(sync_word),
    .chan_data(chan_data), .word_valid(word_valid), .window_word(window_word), .mode_conflict(mode_conflict),
    .seq_error(seq_error));
  ////////////////////////////////////////
  task tick;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task chk10(input [9:0] got, input [9:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task reg_write(input [7:0] a, input [9:0] d);
    begin
      tick;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick;
      reg_wr = 1'b0;
    end
  endtask
  task reg_check(input [7:0] a, input [9:0] e);
    begin
      tick;
      reg_addr = a;
      tick;
      tick;
      chk10(reg_rdata, e);
    end
  endtask
  task do_reset;
    begin
      rst = 1'b1;
      repeat (12) tick;
      rst = 1'b0;
      sid = 10'h02a;
      dtrain = 10'h3a6;
    end
  endtask
  // request held until taken; a window slot leaves it pending
  task slot(input [2:0] s, input [1:0] c, input [9:0] ew, input ewin, input [9:0] ed);
    integer n;
    begin
      sync_req = s;
      class_req = c;
      n = 0;
      tick;
      while (word_valid !== 1'b1 && n < 200) begin
        tick;
        n = n + 1;
      end
      chk10({9'h000, word_valid}, 10'h001);
      chk10(sync_word, ew);
      chk10({8'h00, slot_taken, window_word}, {8'h00, ~ewin, ewin});
      chk10(chan_data[9:0], ed);
      chk10(chan_data[319:310], ed);
      if (slot_taken === 1'b1) sync_req = 3'h0;
    end
  endtask
  ////////////////////////////////////////
  task t_regs;
    begin
      reg_check(8'h82, 10'h3a6);
      reg_check(8'h83, 10'h02a);
      reg_check(8'h84, 10'h015);
      reg_check(8'h85, 10'h035);
      reg_check(8'h86, 10'h059);
      reg_check(8'h87, 10'h3a6);
      reg_check(8'h99, 10'h000);
      reg_write(8'h82, 10'h155);
      dtrain = 10'h155;
      reg_check(8'h82, 10'h155);
      reg_check(8'h87, 10'h3a6);
    end
  endtask
  // frame begin, row finish, row begin, frame finish, each with its window word
  task t_frame(input m8);
    reg [2:0] ty;
    reg [2:0] rq;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        rq = (i == 0) ? 3'h1 : (i == 1) ? 3'h4 : (i == 2) ? 3'h3 : 3'h2;
        ty = (i == 0) ? 3'h5 : (i == 1) ? 3'h2 : (i == 2) ? 3'h1 : 3'h6;
        if (m8) slot(rq, 2'h2, {2'h0, ty, sid[6:2]}, 1'b0, {2'h0, pix_data[9:2]});
        else slot(rq, 2'h2, {ty, sid[6:0]}, 1'b0, pix_data[9:0]);
        if (m8) slot(3'h0, 2'h2, 10'h020, 1'b1, {2'h0, pix_data[9:2]});
        else slot(3'h0, 2'h2, 10'h008, 1'b1, pix_data[9:0]);
      end
      chk10({9'h000, seq_error}, 10'h000);
    end
  endtask
  task t_classes(input m8);
    reg [9:0] code;
    reg [9:0] dat;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        code = (i == 0) ? 10'h3a6 : (i == 1) ? 10'h015 : (i == 2) ? 10'h035 : 10'h059;
        dat = (i == 0) ? dtrain : pix_data[9:0];
        if (m8) slot(3'h0, i[1:0], {2'h0, code[9:2]}, 1'b0, {2'h0, dat[9:2]});
        else slot(3'h0, i[1:0], code, 1'b0, dat);
      end
    end
  endtask
  task t_mode;
    begin
      reg_check(8'h88, 10'h002);
      chk10({9'h000, mode_conflict}, 10'h001);
      reg_write(8'h88, 10'h001);
      reg_write(8'h83, 10'h055);
      sid = 10'h055;
      reg_check(8'h88, 10'h003);
      chk10({9'h000, mode_conflict}, 10'h000);
    end
  endtask
  // a row finish with no row open must raise the sticky bracket error
  task t_bad_order;
    begin
      slot(3'h4, 2'h2, {2'h0, 3'h2, sid[6:2]}, 1'b0, {2'h0, pix_data[9:2]});
      slot(3'h0, 2'h2, 10'h020, 1'b1, {2'h0, pix_data[9:2]});
      chk10({9'h000, seq_error}, 10'h001);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    do_reset;
    t_regs;
    t_frame(1'b0);
    t_classes(1'b0);
    eight_bit = 1'b1;
    do_reset;
    t_mode;
    t_frame(1'b1);
    t_classes(1'b1);
    t_bad_order;
    end_sim;
  end
  // about 1250 cycles expected; cut off well beyond
  initial begin
    #100000;
    bad_count = bad_count + 1;
    end_sim;
  end
endmodule // scwe_sync_encoder_test
